// ---- rtl/tuner_gain_enable_regs.v ----
// Gain offset, bias control and function enable register bank
//
// Functional notes
// - Register 0x1F holds second baseband offset in bits 5:3, first in 2:0.
// - Second baseband code steps 2 dB from -41 dB in bit-reversed order.
// - Register 0x20 holds bias-control disable at bit 4, RF offset at 3:2.
// - Bias disable 0 shuts bias of unused RF stages, 1 only turns them off.
// - RF offset code 00b..11b selects -70, -67, -64, -61 dB.
// - Register 0x21 holds pump, prescaler, baseband, DC fix and RF enables.
// - Each enable is on at 1, off at 0, so all are off after reset.
`timescale 1ns/100ps
`include "tuner_gain_enable_defines.vh"

module tuner_gain_enable_regs (
    // Clock and reset
    input  wire       clk_sys,
    input  wire       srst,
    // Register port
    input  wire [7:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Baseband amplifier offsets, bit-reversed step order
    output wire [2:0] bb_amp_second_offset,
    output wire [2:0] bb_amp_first_offset,
    output wire [2:0] bb_amp_second_step,
    output wire [2:0] bb_amp_first_step,
    // RF amplifier control
    output wire       rf_amp_bias_ctl_disable,
    output wire       rf_amp_bias_shutoff,
    output wire [1:0] rf_amp_offset,
    // Function enables
    output wire       charge_pump_on,
    output wire       prescaler_on,
    output wire       baseband_on,
    output wire       dc_offset_fix_on,
    output wire       rf_amp_on
);

    // Width of a baseband offset code
    localparam BB_CODE_W = 3;

    // Register storage
    reg  [7:0] baseband_amp_offsets;
    reg  [7:0] rf_amp_bias_offset;
    reg  [7:0] function_enables;

    // Next values of the registers and of the read data
    reg  [7:0] next_baseband_amp_offsets;
    reg  [7:0] next_rf_amp_bias_offset;
    reg  [7:0] next_function_enables;
    reg  [7:0] next_rdata;

    // Register selects from the address
    reg        sel_baseband;
    reg        sel_rf;
    reg        sel_enables;

    // Qualified write strobes, one per register
    wire       wr_baseband;
    wire       wr_rf;
    wire       wr_enables;

    // At most one register is selected at a time
    always @* begin
        sel_baseband = 1'b0;
        sel_rf       = 1'b0;
        sel_enables  = 1'b0;
        if (reg_addr == `ADDR_BASEBAND_AMP_OFFSETS) begin
            sel_baseband = 1'b1;
        end else if (reg_addr == `ADDR_RF_AMP_BIAS_OFFSET) begin
            sel_rf = 1'b1;
        end else if (reg_addr == `ADDR_FUNCTION_ENABLES) begin
            sel_enables = 1'b1;
        end
    end

    // Writes to any other address change nothing
    assign wr_baseband = reg_wr & sel_baseband;
    assign wr_rf       = reg_wr & sel_rf;
    assign wr_enables  = reg_wr & sel_enables;

    // Reserved bits are masked at write so they never store a value
    always @* begin
        next_baseband_amp_offsets = baseband_amp_offsets;
        if (wr_baseband) begin
            next_baseband_amp_offsets = reg_wdata
                                        & `MASK_BASEBAND_AMP_OFFSETS;
        end
    end

    always @* begin
        next_rf_amp_bias_offset = rf_amp_bias_offset;
        if (wr_rf) begin
            next_rf_amp_bias_offset = reg_wdata
                                      & `MASK_RF_AMP_BIAS_OFFSET;
        end
    end

    always @* begin
        next_function_enables = function_enables;
        if (wr_enables) begin
            next_function_enables = reg_wdata
                                    & `MASK_FUNCTION_ENABLES;
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            baseband_amp_offsets <= `RST_BASEBAND_AMP_OFFSETS;
        end else begin
            baseband_amp_offsets <= next_baseband_amp_offsets;
        end
    end

    always @(posedge clk_sys) begin
        if (srst) begin
            rf_amp_bias_offset <= `RST_RF_AMP_BIAS_OFFSET;
        end else begin
            rf_amp_bias_offset <= next_rf_amp_bias_offset;
        end
    end

    // All functions come up off
    always @(posedge clk_sys) begin
        if (srst) begin
            function_enables <= `RST_FUNCTION_ENABLES;
        end else begin
            function_enables <= next_function_enables;
        end
    end

    // Idle cycles and unmapped reads give zero, so stale data never shows
    always @* begin
        next_rdata = 8'h00;
        if (reg_rd) begin
            if (sel_baseband) begin
                next_rdata = baseband_amp_offsets;
            end else if (sel_rf) begin
                next_rdata = rf_amp_bias_offset;
            end else if (sel_enables) begin
                next_rdata = function_enables;
            end
        end
    end

    // Read data stands only in the cycle after the strobe
    always @(posedge clk_sys) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    assign bb_amp_second_offset =
        baseband_amp_offsets[`BB2_OFF_HI:`BB2_OFF_LO];
    assign bb_amp_first_offset  =
        baseband_amp_offsets[`BB1_OFF_HI:`BB1_OFF_LO];

    // Codes ascend bit-reversed; the step index is the reversed code
    genvar g;
    generate
        for (g = 0; g < BB_CODE_W; g = g + 1) begin : g_step
            assign bb_amp_second_step[g] =
                bb_amp_second_offset[BB_CODE_W - 1 - g];
            assign bb_amp_first_step[g]  =
                bb_amp_first_offset[BB_CODE_W - 1 - g];
        end
    endgenerate

    assign rf_amp_bias_ctl_disable =
        rf_amp_bias_offset[`RF_BIAS_DIS_BIT];
    // Bias of idle stages is cut only while the disable bit is clear
    assign rf_amp_bias_shutoff = ~rf_amp_bias_ctl_disable;
    // Step index 0..3 maps to -70 dB plus 3 dB per step
    assign rf_amp_offset = rf_amp_bias_offset[`RF_OFF_HI:`RF_OFF_LO];

    assign charge_pump_on   = function_enables[`CP_ON_BIT];
    assign prescaler_on     = function_enables[`PS_ON_BIT];
    assign baseband_on      = function_enables[`BB_ON_BIT];
    assign dc_offset_fix_on = function_enables[`DC_FIX_ON_BIT];
    assign rf_amp_on        = function_enables[`RF_ON_BIT];

endmodule // tuner_gain_enable_regs

// ---- rtl/tuner_gain_enable_defines.vh ----
// Offsets, field positions, reset values and codes of the gain/enable registers
`ifndef TUNER_GAIN_ENABLE_DEFINES_VH
`define TUNER_GAIN_ENABLE_DEFINES_VH

`define ADDR_BASEBAND_AMP_OFFSETS 8'h1F
`define ADDR_RF_AMP_BIAS_OFFSET   8'h20
`define ADDR_FUNCTION_ENABLES     8'h21

`define RST_BASEBAND_AMP_OFFSETS  8'h00
`define RST_RF_AMP_BIAS_OFFSET    8'h00
`define RST_FUNCTION_ENABLES      8'h00

`define MASK_BASEBAND_AMP_OFFSETS 8'h3F
`define MASK_RF_AMP_BIAS_OFFSET   8'h1C
`define MASK_FUNCTION_ENABLES     8'h3D

`define BB2_OFF_HI      5
`define BB2_OFF_LO      3
`define BB1_OFF_HI      2
`define BB1_OFF_LO      0
`define RF_BIAS_DIS_BIT 4
`define RF_OFF_HI       3
`define RF_OFF_LO       2
`define CP_ON_BIT       5
`define PS_ON_BIT       4
`define BB_ON_BIT       3
`define DC_FIX_ON_BIT   2
`define RF_ON_BIT       0

// Offset codes, suggested by software guidance
`define BB2_CODE_FIXED  3'h5
`define BB2_CODE_MIN    3'h3
`define BB2_CODE_MAX    3'h7
`define RF_CODE_MAX     2'h0
`define RF_CODE_MIN     2'h2

`endif

// ---- sim/host_model.sv ----
// Host controller model: one register access per call
`timescale 1ns/100ps
module host_model (input wire clk_sys, input wire [7:0] reg_rdata,
    output reg reg_wr = 1'b0, output reg reg_rd = 1'b0,
    output reg [7:0] reg_addr = 8'h00, output reg [7:0] reg_wdata = 8'h00);
    // Read data taken mid-cycle while it stands
    reg [7:0] rd_seen = 8'h00;
    // Released address and data lines flip, strobes drop to 0, so that a stale value never looks valid
    task acc(input w, input [7:0] a, input [7:0] v);
        begin
            reg_addr <= a;
            reg_wdata <= v;
            reg_wr <= w;
            reg_rd <= !w;
            @(posedge clk_sys);
            reg_addr <= ~a;
            reg_wdata <= ~v;
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
            @(negedge clk_sys);
            rd_seen = reg_rdata;
            @(posedge clk_sys);
        end
    endtask
endmodule // host_model

// ---- sim/tuner_gain_enable_regs_checker.sv ----
// Assertions on the gain/enable register bank ports
`timescale 1ns/100ps
module tge_checker (input wire clk_sys, srst, reg_wr, reg_rd, rf_amp_on,
    input wire rf_amp_bias_ctl_disable, rf_amp_bias_shutoff, charge_pump_on,
    input wire prescaler_on, baseband_on, dc_offset_fix_on,
    input wire [1:0] rf_amp_offset, input wire [7:0] reg_addr, reg_wdata,
    input wire [7:0] reg_rdata, input wire [2:0] bb_amp_second_offset,
    input wire [2:0] bb_amp_first_offset, bb_amp_second_step, bb_amp_first_step);
    wire [4:0] en = {charge_pump_on, prescaler_on, baseband_on,
        dc_offset_fix_on, rf_amp_on};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);
    AST_BB1: assert property (reg_wr && reg_addr == 8'h1f |=>
        bb_amp_first_offset == $past(reg_wdata[2:0])) else $error("bb1");
    AST_BB2: assert property (reg_wr && reg_addr == 8'h1f |=>
        bb_amp_second_offset == $past(reg_wdata[5:3])) else $error("bb2");
    AST_STEP2: assert property (bb_amp_second_step ==
        {<<{bb_amp_second_offset}}) else $error("bb2 step");
    AST_STEP1: assert property (bb_amp_first_step ==
        {<<{bb_amp_first_offset}}) else $error("bb1 step");
    AST_RF: assert property (reg_wr && reg_addr == 8'h20 |=>
        rf_amp_offset == $past(reg_wdata[3:2])) else $error("rf offset");
    AST_SHUT: assert property (rf_amp_bias_shutoff !=
        rf_amp_bias_ctl_disable) else $error("bias shutoff");
    AST_EN: assert property (reg_wr && reg_addr == 8'h21 |=>
        en == {$past(reg_wdata[5:2]), $past(reg_wdata[0])}) else $error("en");
    AST_RST: assert property ($fell(srst) |-> en == 5'h00 &&
        rf_amp_bias_shutoff) else $error("reset state");
    AST_RD: assert property (reg_rd && reg_addr == 8'h21 |=>
        reg_rdata == {2'b00, en[4:1], 1'b0, en[0]}) else $error("read");
    AST_RD_IDLE: assert property (!reg_rd |=>
        reg_rdata == 8'h00) else $error("read data outside answer");
endmodule // tge_checker
bind tuner_gain_enable_regs tge_checker i_tge_checker (.*);

// ---- sim/tb_tuner_gain_enable_regs.sv ----
// Self-checking bench for the gain/enable register bank
`timescale 1ns/100ps
module tb_tuner_gain_enable_regs;
    reg clk_sys = 1'b0, srst = 1'b1;
    wire [7:0] reg_addr, reg_wdata, reg_rdata;
    wire [2:0] bb_amp_second_offset, bb_amp_first_offset, bb_amp_second_step;
    wire [2:0] bb_amp_first_step; wire [1:0] rf_amp_offset;
    wire reg_wr, reg_rd, rf_amp_bias_ctl_disable, rf_amp_bias_shutoff;
    wire charge_pump_on, prescaler_on, baseband_on, dc_offset_fix_on, rf_amp_on;
    wire [4:0] en = {charge_pump_on, prescaler_on, baseband_on,
        dc_offset_fix_on, rf_amp_on};
    integer n_errors = 0, checks_done = 0, cyc = 0, i;
    always #4 clk_sys = ~clk_sys;
    host_model i_host_model (.*);
    tuner_gain_enable_regs i_tuner_gain_enable_regs (.*);
    task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin n_errors = n_errors + 1;
                $display("ERROR %s exp %h got %h", nm, e, g); end
        end
    endtask
    task t_sleep;
        begin
            chk("rst", 8'h01, {en, rf_amp_bias_shutoff});
            i_host_model.acc(1, 8'h21, 8'h3f);
            i_host_model.acc(0, 8'h21, 8'h00);
            chk("en", 8'h3d, i_host_model.rd_seen);
            i_host_model.acc(1, 8'h21, 8'h00);
            chk("off", 8'h00, en);
            i_host_model.acc(1, 8'h22, 8'hff);
            i_host_model.acc(0, 8'h22, 8'h00);
            chk("unmap", 8'h00, i_host_model.rd_seen);
            $display("t_sleep done");
        end
    endtask
    task t_fields;
        begin
            // Reserved bits are set on purpose to see them dropped
            for (i = 0; i < 8; i = i + 1) begin
                i_host_model.acc(1, 8'h1f, {2'b11, i[2:0], ~i[2:0]});
                chk("step", {i[0], i[1], i[2], ~i[0], ~i[1], ~i[2]},
                    {bb_amp_second_step, bb_amp_first_step});
                i_host_model.acc(0, 8'h1f, 8'h00);
                chk("bb", {2'b00, i[2:0], ~i[2:0]},
                    i_host_model.rd_seen);
                i_host_model.acc(1, 8'h20, {3'b111, i[2:0], 2'b11});
                chk("rf", {~i[2], i[2:0]}, {rf_amp_bias_shutoff,
                    rf_amp_bias_ctl_disable, rf_amp_offset});
                i_host_model.acc(0, 8'h20, 8'h00);
                chk("rfrd", {3'b000, i[2:0], 2'b00},
                    i_host_model.rd_seen);
            end
            $display("t_fields done");
        end
    endtask
    task t_advice;
        begin
            i_host_model.acc(1, 8'h1f, 8'h28);
            chk("fixed", 8'h05, bb_amp_second_step);
            i_host_model.acc(1, 8'h1f, 8'h18);
            chk("min", 8'h06, bb_amp_second_step);
            i_host_model.acc(1, 8'h1f, 8'h38);
            chk("max", 8'h07, bb_amp_second_step);
            i_host_model.acc(1, 8'h20, 8'h00);
            chk("rfmax", 8'h00, rf_amp_offset);
            i_host_model.acc(1, 8'h20, 8'h08);
            chk("rfmin", 8'h02, rf_amp_offset);
            i_host_model.acc(1, 8'h21, 8'h3f);
            // Reset in mid-run must clear every register again
            srst <= 1'b1;
            repeat (2) @(posedge clk_sys);
            srst <= 1'b0;
            @(posedge clk_sys);
            chk("rst2", 8'h01, {en, rf_amp_bias_shutoff});
            chk("rst2bb", 8'h00,
                {bb_amp_second_offset, bb_amp_first_offset});
            chk("rst2rf", 8'h00, rf_amp_offset);
            $display("t_advice done");
        end
    endtask
    task finish_test;
        begin
            $display("checks %0d errors %0d", checks_done, n_errors);
            if (n_errors == 0 && checks_done > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (cyc == 2000) begin n_errors = n_errors + 1; finish_test; end
    end
    initial begin
        repeat (4) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        t_sleep;
        t_fields;
        t_advice;
        finish_test;
    end
endmodule // tb_tuner_gain_enable_regs
